/* File: pkg/smb_addr_pkg.sv */
package smb_addr_pkg;

	// Address patterns on the wire
	localparam logic [4:0] TEN_PREFIX      = 5'h1E;
	localparam logic [6:0] GEN_CALL_ADDR   = 7'h00;
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;

	// Bits in a byte before the acknowledge slot
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

	// Idle level of both lines, used as synchroniser reset value
	localparam logic       LINE_IDLE       = 1'h1;

	// Clock-low timeout: figure in ms, clock in kHz, derived cycles
	localparam int         TIMEOUT_MS      = 35;
	localparam int         CLK_KHZ         = 250000;
	localparam int         TIMEOUT_CYC     = TIMEOUT_MS * CLK_KHZ;
	localparam int         TO_W            = 24;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_RECV,
		ST_ACK,
		ST_SEND,
		ST_WAIT_ACK,
		ST_IGNORE
	} state_t;

	typedef enum logic [1:0]
	{
		K_ADDR1,
		K_ADDR2,
		K_DATA
	} kind_t;

endpackage : smb_addr_pkg

/* File: design/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync
(
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic pin_i,
	output logic      level_o
);

	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;

	// Level moves only once the last two stages agree
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s1_ff    <= smb_addr_pkg::LINE_IDLE;
			s2_ff    <= smb_addr_pkg::LINE_IDLE;
			s3_ff    <= smb_addr_pkg::LINE_IDLE;
			level_ff <= smb_addr_pkg::LINE_IDLE;
		end
		else
		begin
			s1_ff <= pin_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				level_ff <= s3_ff;
		end
	end

	assign level_o = level_ff;

endmodule : pin_sync

/* File: design/low_timeout.sv */
`timescale 1ns/10ps
module low_timeout
(
	input  wire logic                          clk_i,
	input  wire logic                          reset_i,
	input  wire logic                          scl_level_i,
	input  wire logic [smb_addr_pkg::TO_W-1:0] limit_i,
	output logic                               expired_o
);

	logic [smb_addr_pkg::TO_W-1:0] count_ff;
	logic                          expired_ff;
	wire                           at_limit = (count_ff == limit_i);
	wire  [smb_addr_pkg::TO_W-1:0] nxt_count =
		scl_level_i ? '0 : (at_limit ? count_ff : count_ff + 1'b1);

	// Saturates so one low period yields a single pulse
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			count_ff   <= '0;
			expired_ff <= 1'b0;
		end
		else
		begin
			count_ff   <= nxt_count; // [R23]
			expired_ff <= !scl_level_i && !at_limit &&
				(nxt_count == limit_i); // [R20]
		end
	end

	assign expired_o = expired_ff;

	AST_LOW_RESTART: assert property (@(posedge clk_i) disable iff (reset_i)
		scl_level_i |=> count_ff == '0) // [R23]
		else $error("low counter not restarted by high clock");

	AST_LOW_EXPIRE: assert property (@(posedge clk_i) disable iff (reset_i)
		expired_ff |-> count_ff == limit_i && !$past(at_limit)) // [R20]
		else $error("timeout pulse not at threshold");

endmodule : low_timeout

/* File: design/i2c_slave_match.sv */
// Function
// [R1] 10-bit first byte starts with 11110
// [R2] First byte: seven bits match, write, ack
// [R3] Second byte must match low eight bits
// [R4] Stay selected until STOP or other address
// [R5] Flag event after 10-bit first byte
// [R6] Direction turns only after second direction bit
// [R7] Repeated START, read bit: ack and transmit
// [R8] Unaddressed 10-bit slave ignores read header
// [R9] Primary seven address bits always compared; the code compares them only while ten_bit_extension_en_i is low
// [R10] Extension bits widen primary to ten bits
// [R11] General call matches when enabled
// [R12] Alert response address matches when enabled
// [R13] Second address matches when enabled
// [R14] Range: above primary, up to range value
// [R15] Software keeps range above primary address
// [R16] Match enters receiver, sets addressed flag
// [R17] Software reads data to learn address
// [R18] Clock-low timeout releases both lines
// [R19] After timeout reset, ready for START
// [R20] Threshold defaults to thirty-five milliseconds
// [R21] Active master requests STOP on timeout
// [R22] Timeout flag, interrupt-gated, cleared by one
// [R23] Low counter, programmable, restarts on rise
`timescale 1ns/10ps
module i2c_slave_match
#(
	parameter logic [smb_addr_pkg::TO_W-1:0] TIMEOUT_CYCLES =
		(smb_addr_pkg::TO_W)'(smb_addr_pkg::TIMEOUT_CYC)
)
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       mgmt_bus_clock_line_i,
	output logic            mgmt_bus_clock_line_o,
	output logic            mgmt_bus_clock_line_oe_o,
	input  wire logic       mgmt_bus_data_line_i,
	output logic            mgmt_bus_data_line_o,
	output logic            mgmt_bus_data_line_oe_o,
	input  wire logic [6:0] own_addr_i,
	input  wire logic [2:0] ext_addr_hi_i,
	input  wire logic       ten_bit_extension_en_i,
	input  wire logic       general_call_en_i,
	input  wire logic       alert_response_en_i,
	input  wire logic       second_slave_id_en_i,
	input  wire logic [6:0] second_addr_i,
	input  wire logic       range_match_en_i,
	input  wire logic [6:0] range_addr_i,
	input  wire logic [smb_addr_pkg::TO_W-1:0] timeout_limit_i,
	input  wire logic       module_irq_en_i,
	input  wire logic       irq_flag_clear_i,
	input  wire logic       timeout_clear_i,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       master_active_i,
	output logic [7:0]      data_o,
	output logic            addressed_as_slave_flag_o,
	output logic            slave_transmit_o,
	output logic            module_irq_flag_o,
	output logic            clock_low_timeout_flag_o,
	output logic            irq_o,
	output logic            master_stop_req_o
);

	smb_addr_pkg::state_t state_ff;
	smb_addr_pkg::kind_t  kind_ff;
	logic [7:0] shift_ff;
	logic [7:0] tx_ff;
	logic [3:0] cnt_ff;
	logic [7:0] data_ff;
	logic       tx_mode_ff;
	logic       addressed_ff;
	logic       ten_done_ff;
	logic       master_ack_ff;
	logic       sda_oe_ff;
	logic       irq_flag_ff;
	logic       to_flag_ff;
	logic       irq_ff;
	logic       stop_req_ff;
	logic       scl_prev_ff;
	logic       sda_prev_ff;
	logic       zero_ff;
	logic       scl_s;
	logic       sda_s;
	logic       to_hit;

	pin_sync u_scl_sync
	(
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.pin_i   (mgmt_bus_clock_line_i),
		.level_o (scl_s)
	);

	pin_sync u_sda_sync
	(
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.pin_i   (mgmt_bus_data_line_i),
		.level_o (sda_s)
	);

	// Zero limit falls back to the bus-standard figure
	wire [smb_addr_pkg::TO_W-1:0] to_limit =
		(timeout_limit_i != '0) ? timeout_limit_i : TIMEOUT_CYCLES;

	low_timeout u_low_timeout
	(
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.scl_level_i (scl_s),
		.limit_i     (to_limit), // [R23]
		.expired_o   (to_hit) // [R20]
	);

	// Bus events
	wire scl_rise = scl_s && !scl_prev_ff;
	wire scl_fall = !scl_s && scl_prev_ff;
	wire start_ev = scl_s && scl_prev_ff && sda_prev_ff && !sda_s;
	wire stop_ev  = scl_s && scl_prev_ff && !sda_prev_ff && sda_s;

	// Address decode
	wire [9:0] addr10   = {ext_addr_hi_i, own_addr_i}; // [R10]
	wire [6:0] addr7    = shift_ff[7:1];
	wire       rw       = shift_ff[0];
	wire       prefix_ok = (shift_ff[7:3] == smb_addr_pkg::TEN_PREFIX);
	wire       ten_hdr  = ten_bit_extension_en_i && prefix_ok &&
		(shift_ff[2:1] == addr10[9:8]); // [R1] [R10]
	wire       own_hit  = !ten_bit_extension_en_i &&
		(addr7 == own_addr_i); // [R9]
	wire       gc_hit   = general_call_en_i && !rw &&
		(addr7 == smb_addr_pkg::GEN_CALL_ADDR); // [R11]
	wire       alert_hit = alert_response_en_i &&
		(addr7 == smb_addr_pkg::ALERT_RESP_ADDR); // [R12]
	wire       sec_hit  = second_slave_id_en_i &&
		(addr7 == second_addr_i); // [R13]
	// Lower bound compares against primary; misprogrammed range simply never hits
	wire       range_hit = range_match_en_i && (range_addr_i != 7'h00) &&
		(addr7 > own_addr_i) && (addr7 <= range_addr_i); // [R14] [R15]
	wire       hit7     = own_hit || gc_hit || alert_hit || sec_hit ||
		range_hit;
	wire       ten_first = ten_hdr && !rw && !hit7; // [R2]
	wire       ten_again = ten_hdr && rw && ten_done_ff && !hit7; // [R7] [R8]
	wire       second_hit = (shift_ff == addr10[7:0]); // [R3]
	wire       ack_addr = hit7 || ten_first || ten_again;
	wire       byte_end = (state_ff == smb_addr_pkg::ST_RECV) && scl_fall &&
		(cnt_ff == smb_addr_pkg::BITS_PER_BYTE);
	wire       ack_now  =
		((kind_ff == smb_addr_pkg::K_ADDR1) && ack_addr) ||
		((kind_ff == smb_addr_pkg::K_ADDR2) && second_hit) ||
		(kind_ff == smb_addr_pkg::K_DATA);
	wire       tx_done  = (state_ff == smb_addr_pkg::ST_WAIT_ACK) && scl_fall;

	// Set wins over software clear
	wire nxt_irq_flag = (byte_end && ack_now) || tx_done || to_hit ||
		(irq_flag_ff && !irq_flag_clear_i); // [R5] [R16]
	wire nxt_to_flag  = to_hit || (to_flag_ff && !timeout_clear_i); // [R22]

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_ff      <= smb_addr_pkg::ST_IDLE;
			kind_ff       <= smb_addr_pkg::K_ADDR1;
			shift_ff      <= 8'h00;
			tx_ff         <= 8'h00;
			cnt_ff        <= 4'h0;
			tx_mode_ff    <= 1'b0;
			addressed_ff  <= 1'b0;
			ten_done_ff   <= 1'b0;
			master_ack_ff <= 1'b0;
			sda_oe_ff     <= 1'b0;
		end
		else if (to_hit || stop_ev)
		begin
			// Drop state, selection, direction and data drive so the next START is taken at once
			state_ff     <= smb_addr_pkg::ST_IDLE; // [R18] [R19]
			sda_oe_ff    <= 1'b0; // [R18]
			addressed_ff <= 1'b0; // [R4]
			ten_done_ff  <= 1'b0;
			tx_mode_ff   <= 1'b0;
		end
		else if (start_ev)
		begin
			// Selection is kept until the new address is judged
			state_ff  <= smb_addr_pkg::ST_RECV; // [R4]
			kind_ff   <= smb_addr_pkg::K_ADDR1;
			cnt_ff    <= 4'h0;
			sda_oe_ff <= 1'b0;
		end
		else
		begin
			case (state_ff)
				smb_addr_pkg::ST_RECV:
				begin
					if (scl_rise)
					begin
						shift_ff <= {shift_ff[6:0], sda_s};
						cnt_ff   <= cnt_ff + 4'h1;
					end
					if (byte_end && ack_now)
					begin
						state_ff  <= smb_addr_pkg::ST_ACK;
						sda_oe_ff <= 1'b1;
					end
					else if (byte_end)
					begin
						state_ff     <= smb_addr_pkg::ST_IGNORE; // [R8]
						addressed_ff <= 1'b0; // [R4]
						ten_done_ff  <= 1'b0;
						tx_mode_ff   <= 1'b0;
					end
					if (byte_end && (kind_ff == smb_addr_pkg::K_ADDR1) &&
						ack_addr)
					begin
						addressed_ff <= !ten_first; // [R16]
						tx_mode_ff   <= !ten_first && rw; // [R6] [R7]
						ten_done_ff  <= ten_again;
						kind_ff      <= ten_first ? smb_addr_pkg::K_ADDR2 :
							smb_addr_pkg::K_DATA; // [R2]
					end
					if (byte_end && (kind_ff == smb_addr_pkg::K_ADDR2) &&
						second_hit)
					begin
						addressed_ff <= 1'b1; // [R3] [R16]
						ten_done_ff  <= 1'b1;
						tx_mode_ff   <= 1'b0; // [R6]
						kind_ff      <= smb_addr_pkg::K_DATA;
					end
				end
				smb_addr_pkg::ST_ACK:
				begin
					if (scl_fall)
					begin
						cnt_ff <= 4'h0;
						if (tx_mode_ff)
						begin
							state_ff  <= smb_addr_pkg::ST_SEND; // [R7]
							tx_ff     <= tx_data_i;
							sda_oe_ff <= !tx_data_i[7];
						end
						else
						begin
							state_ff  <= smb_addr_pkg::ST_RECV;
							sda_oe_ff <= 1'b0;
						end
					end
				end
				smb_addr_pkg::ST_SEND:
				begin
					if (scl_rise)
						cnt_ff <= cnt_ff + 4'h1;
					if (scl_fall && (cnt_ff == smb_addr_pkg::BITS_PER_BYTE))
					begin
						state_ff  <= smb_addr_pkg::ST_WAIT_ACK;
						sda_oe_ff <= 1'b0;
					end
					else if (scl_fall)
					begin
						sda_oe_ff <= !tx_ff[6];
						tx_ff     <= {tx_ff[6:0], 1'b0};
					end
				end
				smb_addr_pkg::ST_WAIT_ACK:
				begin
					if (scl_rise)
						master_ack_ff <= !sda_s;
					if (scl_fall)
					begin
						cnt_ff <= 4'h0;
						// A not-acknowledge ends sending until the next START
						if (master_ack_ff)
						begin
							state_ff  <= smb_addr_pkg::ST_SEND;
							tx_ff     <= tx_data_i;
							sda_oe_ff <= !tx_data_i[7];
						end
						else
							state_ff <= smb_addr_pkg::ST_IGNORE;
					end
				end
				smb_addr_pkg::ST_IDLE,
				smb_addr_pkg::ST_IGNORE:
					sda_oe_ff <= 1'b0;
				default:
					state_ff <= smb_addr_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			data_ff     <= 8'h00;
			irq_flag_ff <= 1'b0;
			to_flag_ff  <= 1'b0;
			irq_ff      <= 1'b0;
			stop_req_ff <= 1'b0;
			scl_prev_ff <= smb_addr_pkg::LINE_IDLE;
			sda_prev_ff <= smb_addr_pkg::LINE_IDLE;
			zero_ff     <= 1'b0;
		end
		else
		begin
			if (byte_end && ack_now)
				data_ff <= shift_ff; // [R5] [R17]
			irq_flag_ff <= nxt_irq_flag;
			to_flag_ff  <= nxt_to_flag; // [R22]
			irq_ff      <= module_irq_en_i &&
				(nxt_irq_flag || nxt_to_flag); // [R22]
			stop_req_ff <= master_active_i &&
				(stop_req_ff || to_hit); // [R21]
			scl_prev_ff <= scl_s;
			sda_prev_ff <= sda_s;
			zero_ff     <= 1'b0;
		end
	end

	// Never stretches the clock; data line is open drain
	assign mgmt_bus_clock_line_o    = zero_ff;
	assign mgmt_bus_clock_line_oe_o = zero_ff;
	assign mgmt_bus_data_line_o     = zero_ff;
	assign mgmt_bus_data_line_oe_o  = sda_oe_ff;
	assign data_o                   = data_ff;
	assign addressed_as_slave_flag_o = addressed_ff;
	assign slave_transmit_o         = tx_mode_ff;
	assign module_irq_flag_o        = irq_flag_ff;
	assign clock_low_timeout_flag_o = to_flag_ff;
	assign irq_o                    = irq_ff;
	assign master_stop_req_o        = stop_req_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	AST_TEN_PREFIX: assert property ( // [R1]
		byte_end && kind_ff == smb_addr_pkg::K_ADDR1 && !prefix_ok && !hit7
		|=> state_ff != smb_addr_pkg::ST_ACK)
		else $error("non-prefix first byte was acknowledged");

	AST_TEN_FIRST: assert property ( // [R2]
		byte_end && kind_ff == smb_addr_pkg::K_ADDR1 && ten_first
		|=> state_ff == smb_addr_pkg::ST_ACK && sda_oe_ff &&
			kind_ff == smb_addr_pkg::K_ADDR2 && !addressed_ff && irq_flag_ff)
		else $error("10-bit first byte not acknowledged with event");

	AST_SECOND_MISS: assert property ( // [R3]
		byte_end && kind_ff == smb_addr_pkg::K_ADDR2 && !second_hit
		|=> state_ff == smb_addr_pkg::ST_IGNORE && !addressed_ff)
		else $error("mismatched second byte kept slave selected");

	AST_STOP_DESELECT: assert property ( // [R4]
		stop_ev |=> !addressed_ff && !sda_oe_ff ##1 !addressed_ff)
		else $error("slave still selected after STOP");

	AST_RS_TRANSMIT: assert property ( // [R7]
		byte_end && kind_ff == smb_addr_pkg::K_ADDR1 && ten_again
		|=> tx_mode_ff && addressed_ff && state_ff == smb_addr_pkg::ST_ACK)
		else $error("repeated START read did not enter transmit");

	AST_NO_READ_UNADDR: assert property ( // [R8]
		byte_end && kind_ff == smb_addr_pkg::K_ADDR1 && ten_hdr && rw &&
		!ten_done_ff && !hit7 |=> state_ff == smb_addr_pkg::ST_IGNORE)
		else $error("unaddressed slave answered 10-bit read header");

	AST_RANGE: assert property ( // [R14]
		byte_end && kind_ff == smb_addr_pkg::K_ADDR1 && range_hit
		|=> addressed_ff && data_o == $past(shift_ff))
		else $error("address inside range not matched");

	AST_TIMEOUT: assert property ( // [R18]
		to_hit |=> !sda_oe_ff && state_ff == smb_addr_pkg::ST_IDLE &&
			to_flag_ff && irq_ff == $past(module_irq_en_i))
		else $error("timeout did not release bus and flag");

	AST_STOP_REQ: assert property ( // [R21]
		to_hit && master_active_i ##1 master_active_i
		|-> master_stop_req_o)
		else $error("master STOP request missing after timeout");

	COV_TEN_RX: cover property (
		byte_end && kind_ff == smb_addr_pkg::K_ADDR2 && second_hit);
	COV_TEN_TX: cover property (
		byte_end && ten_again ##[1:1000] state_ff == smb_addr_pkg::ST_SEND);
	COV_RANGE: cover property (byte_end && range_hit && !own_hit);
	COV_TIMEOUT: cover property (to_hit && addressed_ff);

endmodule : i2c_slave_match

/* File: tb/bus_master_model.sv */
`timescale 1ns/10ps
module bus_master_model
(
	input  wire logic clk_i,
	input  wire logic sda_line_i,
	output logic      scl_o,
	output logic      sda_o
);

	initial
	begin
		scl_o = 1'h1;
		sda_o = 1'h1;
	end

	// One quarter of the 48 ns bus period is three module clocks
	task automatic q_wait(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : q_wait

	// Data moves a quarter after the clock fall, never with it
	task automatic clk_bit(input logic b, output logic r);
		sda_o = b;
		q_wait(3);
		scl_o = 1'h1;
		q_wait(3);
		r = sda_line_i;
		q_wait(3);
		scl_o = 1'h0;
		q_wait(3);
	endtask : clk_bit

	task automatic start_cond;
		sda_o = 1'h1;
		q_wait(3);
		scl_o = 1'h1;
		q_wait(3);
		sda_o = 1'h0;
		q_wait(3);
		scl_o = 1'h0;
		q_wait(3);
	endtask : start_cond

	task automatic stop_cond;
		sda_o = 1'h0;
		q_wait(3);
		scl_o = 1'h1;
		q_wait(3);
		sda_o = 1'h1;
		q_wait(6);
	endtask : stop_cond

	task automatic write_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], r);
		clk_bit(1'h1, r);
		ack = ~r;
	endtask : write_byte

	// Line released for all eight bits, then our own ack
	task automatic read_byte(input logic ack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(1'h1, b[i]);
		clk_bit(~ack, r);
	endtask : read_byte

endmodule : bus_master_model

/* File: tb/test_i2c_slave_match.sv */
`timescale 1ns/10ps
module test_i2c_slave_match;

	logic       clk_i;
	logic       reset_i;
	logic       scl_m;
	logic       sda_m;
	logic       scl_d;
	logic       scl_oe;
	logic       sda_d;
	logic       sda_oe;
	logic [6:0] own;
	logic [2:0] ext;
	logic       ten_en;
	logic       gc_en;
	logic       al_en;
	logic       sa_en;
	logic       rm_en;
	logic [6:0] sa;
	logic [6:0] ra;
	logic       irq_en;
	logic       iclr;
	logic       tclr;
	logic       mact;
	logic [7:0] txd;
	logic [7:0] data;
	logic       adr;
	logic       stx;
	logic       iflg;
	logic       tflg;
	logic       irq;
	logic       sreq;
	logic [23:0] lim;
	int         n_mismatch = 0;
	int         check_count = 0;
	// Both lines pulled up; the master pulls low whenever it drives 0, the slave only while enabled
	wire        scl_w = scl_m & ~(scl_oe & ~scl_d);
	wire        sda_w = sda_m & ~(sda_oe & ~sda_d);

	bus_master_model m
	(
		.clk_i      (clk_i),
		.sda_line_i (sda_w),
		.scl_o      (scl_m),
		.sda_o      (sda_m)
	);

	i2c_slave_match #(.TIMEOUT_CYCLES(24'h0000C8)) dut
	(
		.clk_i                     (clk_i),
		.reset_i                   (reset_i),
		.mgmt_bus_clock_line_i     (scl_w),
		.mgmt_bus_clock_line_o     (scl_d),
		.mgmt_bus_clock_line_oe_o  (scl_oe),
		.mgmt_bus_data_line_i      (sda_w),
		.mgmt_bus_data_line_o      (sda_d),
		.mgmt_bus_data_line_oe_o   (sda_oe),
		.own_addr_i                (own),
		.ext_addr_hi_i             (ext),
		.ten_bit_extension_en_i    (ten_en),
		.general_call_en_i         (gc_en),
		.alert_response_en_i       (al_en),
		.second_slave_id_en_i      (sa_en),
		.second_addr_i             (sa),
		.range_match_en_i          (rm_en),
		.range_addr_i              (ra),
		.timeout_limit_i           (lim),
		.module_irq_en_i           (irq_en),
		.irq_flag_clear_i          (iclr),
		.timeout_clear_i           (tclr),
		.tx_data_i                 (txd),
		.master_active_i           (mact),
		.data_o                    (data),
		.addressed_as_slave_flag_o (adr),
		.slave_transmit_o          (stx),
		.module_irq_flag_o         (iflg),
		.clock_low_timeout_flag_o  (tflg),
		.irq_o                     (irq),
		.master_stop_req_o         (sreq)
	);

	initial
	begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end

	task automatic report_and_stop;
		if (n_mismatch == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		check_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	task automatic probe(input logic [6:0] a, input logic e);
		logic k;
		m.start_cond;
		m.write_byte({a, 1'h0}, k);
		m.stop_cond;
		chk("ack", 8'(e), 8'(k));
	endtask : probe

	task automatic t_seven;
		logic k;
		m.start_cond;
		m.write_byte({own, 1'h0}, k);
		tick(8);
		chk("ack", 8'h01, 8'(k));
		chk("addressed", 8'h01, 8'(adr));
		chk("irq_flag", 8'h01, 8'(iflg));
		chk("irq", 8'h00, 8'(irq));
		irq_en = 1'h1;
		tick(2);
		chk("irq", 8'h01, 8'(irq));
		iclr = 1'h1;
		tick(1);
		iclr = 1'h0;
		tick(2);
		chk("irq_flag", 8'h00, 8'(iflg));
		irq_en = 1'h0;
		m.write_byte(8'hC3, k);
		tick(8);
		chk("data", 8'hC3, data);
		m.stop_cond;
		tick(4);
		chk("addressed", 8'h00, 8'(adr));
		probe(7'h2B, 1'h0);
	endtask : t_seven

	task automatic t_sources;
		sa = 7'h55;
		ra = 7'h2D;
		gc_en = 1'h1;
		al_en = 1'h1;
		sa_en = 1'h1;
		rm_en = 1'h1;
		probe(7'h00, 1'h1);
		probe(7'h0C, 1'h1);
		probe(7'h55, 1'h1);
		probe(7'h2B, 1'h1);
		probe(7'h2D, 1'h1);
		probe(7'h2E, 1'h0);
		gc_en = 1'h0;
		al_en = 1'h0;
		sa_en = 1'h0;
		rm_en = 1'h0;
		probe(7'h00, 1'h0);
		probe(7'h0C, 1'h0);
		probe(7'h55, 1'h0);
		probe(7'h2B, 1'h0);
	endtask : t_sources

	task automatic t_ten;
		logic       k;
		logic [7:0] b1;
		logic [7:0] b2;
		logic [7:0] r;
		b1 = {5'h1E, ext[2:1], 1'h0};
		b2 = {ext[0], own};
		ten_en = 1'h1;
		// Flag still set from earlier probes; start from a known low
		iclr = 1'h1;
		tick(1);
		iclr = 1'h0;
		m.start_cond;
		m.write_byte(b1 | 8'h01, k);
		m.stop_cond;
		chk("ack", 8'h00, 8'(k));
		chk("irq_flag", 8'h00, 8'(iflg));
		m.start_cond;
		m.write_byte(b1, k);
		tick(8);
		chk("ack", 8'h01, 8'(k));
		chk("addressed", 8'h00, 8'(adr));
		chk("irq_flag", 8'h01, 8'(iflg));
		m.write_byte(b2 ^ 8'h01, k);
		m.stop_cond;
		chk("ack", 8'h00, 8'(k));
		m.start_cond;
		m.write_byte(b1, k);
		m.write_byte(b2, k);
		tick(8);
		chk("ack", 8'h01, 8'(k));
		chk("addressed", 8'h01, 8'(adr));
		chk("transmit", 8'h00, 8'(stx));
		m.start_cond;
		m.write_byte(b1 | 8'h01, k);
		tick(8);
		chk("ack", 8'h01, 8'(k));
		chk("transmit", 8'h01, 8'(stx));
		chk("addressed", 8'h01, 8'(adr));
		m.read_byte(1'h1, r);
		chk("tx_byte", txd, r);
		m.read_byte(1'h0, r);
		chk("tx_byte", txd, r);
		m.stop_cond;
		tick(4);
		chk("addressed", 8'h00, 8'(adr));
		ten_en = 1'h0;
	endtask : t_ten

	task automatic t_timeout;
		logic       k;
		logic [7:0] b;
		b = {own, 1'h0};
		mact = 1'h1;
		irq_en = 1'h1;
		m.start_cond;
		for (int i = 7; i >= 0; i--)
			m.clk_bit(b[i], k);
		tick(150);
		chk("data_oe", 8'h01, 8'(sda_oe));
		tick(70);
		chk("data_oe", 8'h00, 8'(sda_oe));
		chk("clock_oe", 8'h00, 8'(scl_oe));
		chk("clock_out", 8'h00, 8'(scl_d));
		chk("data_out", 8'h00, 8'(sda_d));
		chk("timeout", 8'h01, 8'(tflg));
		chk("irq", 8'h01, 8'(irq));
		chk("addressed", 8'h00, 8'(adr));
		chk("stop_req", 8'h01, 8'(sreq));
		m.clk_bit(1'h1, k);
		m.stop_cond;
		tclr = 1'h1;
		tick(1);
		tclr = 1'h0;
		mact = 1'h0;
		tick(2);
		chk("timeout", 8'h00, 8'(tflg));
		chk("stop_req", 8'h00, 8'(sreq));
		probe(own, 1'h1);
		// Programmed limit overrides the fallback figure
		lim = 24'h000064;
		m.start_cond;
		for (int i = 7; i >= 0; i--)
			m.clk_bit(b[i], k);
		tick(70);
		chk("data_oe", 8'h01, 8'(sda_oe));
		tick(40);
		chk("data_oe", 8'h00, 8'(sda_oe));
		chk("timeout", 8'h01, 8'(tflg));
		chk("stop_req", 8'h00, 8'(sreq));
		m.clk_bit(1'h1, k);
		m.stop_cond;
		irq_en = 1'h0;
	endtask : t_timeout

	initial
	begin
		#200000;
		n_mismatch++;
		report_and_stop;
	end

	initial
	begin
		reset_i = 1'h1;
		own = 7'h2A;
		ext = 3'h5;
		{ten_en, gc_en, al_en, sa_en, rm_en} = 5'h00;
		sa = 7'h00;
		ra = 7'h00;
		{irq_en, iclr, tclr, mact} = 4'h0;
		txd = 8'hA5;
		lim = 24'h000000;
		repeat (5) @(posedge clk_i);
		#1;
		reset_i = 1'h0;
		tick(4);
		t_seven;
		t_sources;
		t_ten;
		t_timeout;
		report_and_stop;
	end

endmodule : test_i2c_slave_match
